// [hw/eaa_arbiter.sv]
// eeprom array with hub read port, programming engine and arbitration

// Function
// - array addressed as sixteen-byte rows
// - row count is a build parameter of 32, 64 or 128
// - every hub read returns exactly one byte
// - only the programming engine writes or erases; hub writes refused
// - erase a 64-row sector or everything; program one full row
// - hub access while engine owns raises fault interrupt, error bit 0
// - fault flag stays set until the error register is read
// - sleep request at control bit 4, resets zero, one sleeps
// - awake status at control bit 5 reads one when awake
// - control bit 1 picks contention winner, zero favours hub
module eaa_arbiter #(
  parameter int ROWS = eaa_pkg::ROWS_DEFAULT,
  parameter int WRITE_CYCLES = eaa_pkg::WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pc_cmd_valid,
  output logic pc_cmd_ready,
  input wire logic [1:0] pc_cmd,
  input wire logic [6:0] pc_row,
  input wire logic [127:0] pc_data,
  output logic pc_busy,
  output logic pc_done,
  output logic sys_fault,
  output logic irq
);

  localparam int ARR_BYTES = ROWS * eaa_pkg::ROW_BYTES;
  localparam logic [19:0] CNT_LOAD = 20'(WRITE_CYCLES - 1);

  typedef struct packed {
    logic sleep_req;
    logic awake;
    logic prio;
    logic hreq;
    logic ack;
    logic fault;
    logic [1:0] irq_st;
    logic [1:0] irq_msk;
    logic irq;
    logic sys_fault;
    eaa_pkg::eaa_state_e st;
    logic [1:0] cmd;
    logic [6:0] row;
    logic [127:0] data;
    logic [19:0] cnt;
    logic cmd_ready;
    logic busy;
    logic done;
  } eaa_arb_s;

  eaa_arb_s q_ff;
  eaa_arb_s nxt_q;
  logic [7:0] mem [ARR_BYTES];
  logic grant;
  logic owns;
  logic [10:0] rd_idx;
  logic [10:0] wr_idx;

  eaa_rbus_if rb ();

  eaa_axil_slave u_slave (
    .clk(clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb)
  );

  // --------------------------------------------------------------------
  // ownership and arbitration
  // --------------------------------------------------------------------
  assign owns = (q_ff.st == eaa_pkg::EAA_BUSY);
  // a held hub grant blocks the engine unless the engine has priority
  assign grant = (q_ff.st == eaa_pkg::EAA_WAIT) && q_ff.awake &&
                 (!q_ff.ack || q_ff.prio);
  assign rd_idx = rb.rd_addr[12:2];
  assign wr_idx = rb.wr_addr[12:2];

  // --------------------------------------------------------------------
  // register file, hub port and engine sequencing
  // --------------------------------------------------------------------
  always_comb begin
    logic fault_evt;
    logic done_evt;
    fault_evt = 1'b0;
    done_evt = 1'b0;
    nxt_q = q_ff;
    nxt_q.sys_fault = 1'b0;
    nxt_q.done = 1'b0;
    rb.rdata = '0;
    rb.rd_err = 1'b0;
    rb.wr_err = 1'b0;

    // read side
    if (rb.rd_req) begin
      if (rb.rd_addr[eaa_pkg::WIN_BIT]) begin
        if (32'(rd_idx) >= ARR_BYTES) begin
          rb.rd_err = 1'b1;
        end else if (owns) begin
          rb.rd_err = 1'b1;
          fault_evt = 1'b1;
        end else if (!q_ff.awake || !q_ff.ack) begin
          // request not granted by the handshake, nothing read
          rb.rd_err = 1'b1;
        end else begin
          rb.rdata = {24'h000000, mem[rd_idx]};
        end
      end else begin
        case (rb.rd_addr)
          eaa_pkg::OFS_CTRL: begin
            rb.rdata[eaa_pkg::CTRL_PRIO_BIT] = q_ff.prio;
            rb.rdata[eaa_pkg::CTRL_SLEEP_BIT] = q_ff.sleep_req;
            rb.rdata[eaa_pkg::CTRL_AWAKE_BIT] = q_ff.awake;
          end
          eaa_pkg::OFS_HSHK: begin
            rb.rdata[eaa_pkg::HSHK_REQ_BIT] = q_ff.hreq;
            rb.rdata[eaa_pkg::HSHK_ACK_BIT] = q_ff.ack;
          end
          eaa_pkg::OFS_ERR: begin
            rb.rdata[eaa_pkg::ERR_FAULT_BIT] = q_ff.fault;
            nxt_q.fault = 1'b0;
          end
          eaa_pkg::OFS_IRQ_ST: begin
            rb.rdata[1:0] = q_ff.irq_st;
          end
          eaa_pkg::OFS_IRQ_MSK: begin
            rb.rdata[1:0] = q_ff.irq_msk;
          end
          default: begin
            rb.rd_err = 1'b1;
          end
        endcase
      end
    end

    // write side
    if (rb.wr_req) begin
      if (rb.wr_addr[eaa_pkg::WIN_BIT]) begin
        // the array is only ever changed by the engine
        rb.wr_err = 1'b1;
        if (owns && 32'(wr_idx) < ARR_BYTES) begin
          fault_evt = 1'b1;
        end
      end else begin
        case (rb.wr_addr)
          eaa_pkg::OFS_CTRL: begin
            if (rb.wstrb[0]) begin
              nxt_q.prio = rb.wdata[eaa_pkg::CTRL_PRIO_BIT];
              nxt_q.sleep_req = rb.wdata[eaa_pkg::CTRL_SLEEP_BIT];
            end
          end
          eaa_pkg::OFS_HSHK: begin
            if (rb.wstrb[0]) begin
              nxt_q.hreq = rb.wdata[eaa_pkg::HSHK_REQ_BIT];
            end
          end
          eaa_pkg::OFS_ERR: begin
          end
          eaa_pkg::OFS_IRQ_ST: begin
            if (rb.wstrb[0]) begin
              nxt_q.irq_st = q_ff.irq_st & ~rb.wdata[1:0];
            end
          end
          eaa_pkg::OFS_IRQ_MSK: begin
            if (rb.wstrb[0]) begin
              nxt_q.irq_msk = rb.wdata[1:0];
            end
          end
          default: begin
            rb.wr_err = 1'b1;
          end
        endcase
      end
    end

    // awake follows the sleep request one cycle later
    nxt_q.awake = !q_ff.sleep_req;

    // engine: a command waits for the array, then owns it for the write
    nxt_q.cmd_ready = 1'b0;
    case (q_ff.st)
      eaa_pkg::EAA_IDLE: begin
        nxt_q.cmd_ready = 1'b1;
        if (pc_cmd_valid && q_ff.cmd_ready) begin
          nxt_q.cmd = pc_cmd;
          nxt_q.row = pc_row;
          nxt_q.data = pc_data;
          nxt_q.cmd_ready = 1'b0;
          nxt_q.st = eaa_pkg::EAA_WAIT;
        end
      end
      eaa_pkg::EAA_WAIT: begin
        if (grant) begin
          nxt_q.cnt = CNT_LOAD;
          nxt_q.st = eaa_pkg::EAA_BUSY;
        end
      end
      eaa_pkg::EAA_BUSY: begin
        // busy stays high through the whole write time
        if (q_ff.cnt == '0) begin
          done_evt = 1'b1;
          nxt_q.done = 1'b1;
          nxt_q.st = eaa_pkg::EAA_IDLE;
        end else begin
          nxt_q.cnt = q_ff.cnt - 20'h00001;
        end
      end
      default: begin
        nxt_q.st = eaa_pkg::EAA_IDLE;
      end
    endcase
    nxt_q.busy = (nxt_q.st != eaa_pkg::EAA_IDLE);

    // acknowledge only to a live request while the engine keeps off
    nxt_q.ack = nxt_q.hreq && q_ff.awake && !owns && !grant &&
                !(nxt_q.st == eaa_pkg::EAA_BUSY);

    // events are applied after the clears so that a set wins
    if (fault_evt) begin
      nxt_q.fault = 1'b1;
      nxt_q.sys_fault = 1'b1;
      nxt_q.irq_st[eaa_pkg::IRQ_FAULT_BIT] = 1'b1;
    end
    if (done_evt) begin
      nxt_q.irq_st[eaa_pkg::IRQ_DONE_BIT] = 1'b1;
    end
    nxt_q.irq = |(nxt_q.irq_st & nxt_q.irq_msk);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= '0;
      q_ff.sleep_req <= eaa_pkg::RST_SLEEP;
      q_ff.awake <= eaa_pkg::RST_AWAKE;
      q_ff.prio <= eaa_pkg::RST_PRIO;
      q_ff.irq_msk <= eaa_pkg::RST_IRQ_MSK;
      q_ff.st <= eaa_pkg::EAA_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // --------------------------------------------------------------------
  // array update at the moment of grant
  // --------------------------------------------------------------------
  // the whole row or sector changes in one edge; the following write
  // time only keeps the hub off, which trades area for simplicity
  always_ff @(posedge clk) begin
    if (grant && int'(q_ff.row) < ROWS) begin
      for (int r = 0; r < ROWS; r++) begin
        for (int b = 0; b < eaa_pkg::ROW_BYTES; b++) begin
          case (q_ff.cmd)
            eaa_pkg::EAA_CMD_PROGRAM: begin
              if (r == int'(q_ff.row)) begin
                mem[r * eaa_pkg::ROW_BYTES + b] <=
                  q_ff.data[b * 8 +: 8];
              end
            end
            eaa_pkg::EAA_CMD_ERASE_SECTOR: begin
              if (r / eaa_pkg::SECTOR_ROWS ==
                  int'(q_ff.row) / eaa_pkg::SECTOR_ROWS) begin
                mem[r * eaa_pkg::ROW_BYTES + b] <=
                  eaa_pkg::ERASED_BYTE;
              end
            end
            eaa_pkg::EAA_CMD_ERASE_ALL: begin
              mem[r * eaa_pkg::ROW_BYTES + b] <=
                eaa_pkg::ERASED_BYTE;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  // ROWS must be 32, 64 or 128; the array is one block of that size
  assign pc_cmd_ready = q_ff.cmd_ready;
  assign pc_busy = q_ff.busy;
  assign pc_done = q_ff.done;
  assign sys_fault = q_ff.sys_fault;
  assign irq = q_ff.irq;

endmodule : eaa_arbiter

// [inc/eaa_pkg.sv]
// shared constants and types of the eeprom access arbiter
package eaa_pkg;

  // --------------------------------------------------------------------
  // array geometry
  // --------------------------------------------------------------------
  localparam int ROW_BYTES = 16;
  localparam int SECTOR_ROWS = 64;
  localparam int ROWS_DEFAULT = 128;
  localparam int ROW_W = 7;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // --------------------------------------------------------------------
  // bus map (byte addresses)
  // --------------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam logic [13:0] OFS_CTRL = 14'h0000;
  localparam logic [13:0] OFS_HSHK = 14'h0004;
  localparam logic [13:0] OFS_ERR = 14'h0008;
  localparam logic [13:0] OFS_IRQ_ST = 14'h000c;
  localparam logic [13:0] OFS_IRQ_MSK = 14'h0010;
  // array window: address bit 13 set, one byte per aligned word
  localparam int WIN_BIT = 13;

  // --------------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------------
  localparam int CTRL_PRIO_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 4;
  localparam int CTRL_AWAKE_BIT = 5;
  localparam int HSHK_REQ_BIT = 0;
  localparam int HSHK_ACK_BIT = 1;
  localparam int ERR_FAULT_BIT = 0;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam logic RST_SLEEP = 1'b0;
  localparam logic RST_AWAKE = 1'b1;
  localparam logic RST_PRIO = 1'b0;
  localparam logic [1:0] RST_IRQ_MSK = 2'h0;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int WRITE_TIME_MS = 20;
  localparam int WRITE_CYCLES = WRITE_TIME_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 20;

  // --------------------------------------------------------------------
  // bus responses, commands, states
  // --------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EAA_CMD_PROGRAM = 2'h0,
    EAA_CMD_ERASE_SECTOR = 2'h1,
    EAA_CMD_ERASE_ALL = 2'h2
  } eaa_cmd_e;

  typedef enum logic [1:0] {
    EAA_IDLE = 2'h0,
    EAA_WAIT = 2'h1,
    EAA_BUSY = 2'h3
  } eaa_state_e;

endpackage : eaa_pkg

// [inc/eaa_rbus_if.sv]
// register access requests between the bus slave and the register file
interface eaa_rbus_if;
  logic wr_req;
  logic [13:0] wr_addr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_err;
  logic rd_req;
  logic [13:0] rd_addr;
  logic [31:0] rdata;
  logic rd_err;

  modport slave (
    output wr_req, wr_addr, wdata, wstrb, rd_req, rd_addr,
    input wr_err, rdata, rd_err
  );
  modport regs (
    input wr_req, wr_addr, wdata, wstrb, rd_req, rd_addr,
    output wr_err, rdata, rd_err
  );
endinterface : eaa_rbus_if

// [hw/eaa_axil_slave.sv]
// axi4-lite slave front end, one write and one read under way at a time
module eaa_axil_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  eaa_rbus_if.slave rb
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_hold;
    logic w_hold;
    logic ar_hold;
    logic [13:0] awaddr;
    logic [13:0] araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } eaa_slv_s;

  eaa_slv_s q_ff;
  eaa_slv_s nxt_q;

  // --------------------------------------------------------------------
  // channel handling
  // --------------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    if (s_axi_awvalid && q_ff.awready) begin
      nxt_q.aw_hold = 1'b1;
      nxt_q.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_ff.wready) begin
      nxt_q.w_hold = 1'b1;
      nxt_q.wdata = s_axi_wdata;
      nxt_q.wstrb = s_axi_wstrb;
    end
    if (q_ff.bvalid && s_axi_bready) begin
      nxt_q.bvalid = 1'b0;
    end
    // the write is acted on only once address and data are both held
    if (rb.wr_req) begin
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp = rb.wr_err ? eaa_pkg::RESP_SLVERR : eaa_pkg::RESP_OKAY;
      nxt_q.aw_hold = 1'b0;
      nxt_q.w_hold = 1'b0;
    end
    if (s_axi_arvalid && q_ff.arready) begin
      nxt_q.ar_hold = 1'b1;
      nxt_q.araddr = s_axi_araddr;
    end
    if (q_ff.rvalid && s_axi_rready) begin
      nxt_q.rvalid = 1'b0;
    end
    if (rb.rd_req) begin
      nxt_q.rvalid = 1'b1;
      nxt_q.rdata = rb.rdata;
      nxt_q.rresp = rb.rd_err ? eaa_pkg::RESP_SLVERR : eaa_pkg::RESP_OKAY;
      nxt_q.ar_hold = 1'b0;
    end
    nxt_q.awready = !nxt_q.aw_hold;
    nxt_q.wready = !nxt_q.w_hold;
    nxt_q.arready = !nxt_q.ar_hold;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign rb.wr_req = q_ff.aw_hold && q_ff.w_hold && !q_ff.bvalid;
  assign rb.wr_addr = q_ff.awaddr;
  assign rb.wdata = q_ff.wdata;
  assign rb.wstrb = q_ff.wstrb;
  assign rb.rd_req = q_ff.ar_hold && !q_ff.rvalid;
  assign rb.rd_addr = q_ff.araddr;

  assign s_axi_awready = q_ff.awready;
  assign s_axi_wready = q_ff.wready;
  assign s_axi_arready = q_ff.arready;
  assign s_axi_bvalid = q_ff.bvalid;
  assign s_axi_bresp = q_ff.bresp;
  assign s_axi_rvalid = q_ff.rvalid;
  assign s_axi_rresp = q_ff.rresp;
  assign s_axi_rdata = q_ff.rdata;

endmodule : eaa_axil_slave

// [test/eaa_arbiter_checker.sv]
// port-level assertions of the eeprom access arbiter
module eaa_arbiter_checker #(
  parameter int WRITE_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pc_cmd_valid,
  input wire logic pc_cmd_ready,
  input wire logic pc_busy,
  input wire logic pc_done,
  input wire logic sys_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // busy cycles seen by the done pulse; a short count would hand the
  // array back to the hub before the write time ran out
  logic [19:0] busy_cnt_ff;
  always_ff @(posedge clk) begin
    busy_cnt_ff <= (rst || !pc_busy) ? 20'h0 : busy_cnt_ff + 20'h1;
  end
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
      !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid && s_axi_awready;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("bad b");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=>
      !s_axi_rvalid ##1 s_axi_rvalid && s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("bad r");
  property p_read_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_read_byte: assert property (p_read_byte)
    else $error("wide read");
  property p_read_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_read_stand: assert property (p_read_stand)
    else $error("r moved");
  property p_take_cmd;
    pc_cmd_valid && pc_cmd_ready |=> pc_busy && !pc_cmd_ready;
  endproperty
  a_take_cmd: assert property (p_take_cmd) else $error("cmd lost");
  property p_done_end;
    pc_done |-> !pc_busy && $past(pc_busy) ##1 !pc_done;
  endproperty
  a_done_end: assert property (p_done_end) else $error("bad done");
  property p_busy_len;
    pc_done |-> busy_cnt_ff >= WRITE_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("short");
  property p_fault_pulse;
    sys_fault |=> !sys_fault;
  endproperty
  a_fault_pulse: assert property (p_fault_pulse)
    else $error("fault");
endmodule : eaa_arbiter_checker

bind eaa_arbiter eaa_arbiter_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk_i (.*);

// [test/eaa_pc_model.sv]
// programming controller model: one command held until taken
module eaa_pc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [1:0] cmd,
  input wire logic [6:0] row,
  input wire logic [127:0] data,
  input wire logic pc_cmd_ready,
  output logic pc_cmd_valid = 1'b0,
  output logic [1:0] pc_cmd = 2'h0,
  output logic [6:0] pc_row = 7'h0,
  output logic [127:0] pc_data = 128'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    if (rst) begin
      pc_cmd_valid <= 1'b0;
    end else if (pc_cmd_valid && pc_cmd_ready) begin
      // released row and data are scrambled so nobody leans on stale values
      pc_cmd_valid <= 1'b0;
      pc_row <= ~pc_row;
      pc_data <= ~pc_data;
    end else if (go && !pc_cmd_valid) begin
      pc_cmd_valid <= 1'b1;
      pc_cmd <= cmd;
      pc_row <= row;
      pc_data <= data;
    end
  end
endmodule : eaa_pc_model

// [test/test_eaa_arbiter.sv]
// self-checking bench of the eeprom access arbiter
module test_eaa_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WRITE_CYCLES = 40;
  localparam logic [33:0] SLV = {eaa_pkg::RESP_SLVERR, 32'h0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] s_axi_awaddr = 14'h0;
  logic [13:0] s_axi_araddr = 14'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pc_cmd_valid, pc_cmd_ready, pc_busy, pc_done;
  logic sys_fault, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, pc_cmd;
  logic [31:0] s_axi_rdata;
  logic [6:0] pc_row;
  logic [127:0] pc_data;
  logic go = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [6:0] row = 7'h0;
  logic [127:0] data = 128'h0;
  logic [7:0] rnd = 8'h3f;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int faults = 0;

  always #10 clk = ~clk;

  eaa_arbiter #(.ROWS(128), .WRITE_CYCLES(WRITE_CYCLES)) dut (.*);
  eaa_pc_model pc (.*);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  function automatic logic [33:0] ok(input logic [31:0] d);
    return {eaa_pkg::RESP_OKAY, d};
  endfunction : ok
  function automatic logic [13:0] arr(input int i);
    return 14'h2000 + 14'(4 * i);
  endfunction : arr
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [13:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    @(posedge clk);
    exp_b.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [13:0] a, input logic [33:0] e);
    @(posedge clk);
    exp_r.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic run_cmd(input logic [1:0] c, input logic [6:0] r);
    @(posedge clk);
    cmd <= c;
    row <= r;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : run_cmd
  task automatic wait_done;
    int n;
    n = 0;
    while (pc_done !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk({33'h0, pc_done}, 34'h1);
  endtask : wait_done
  task automatic see_irq(input logic e);
    repeat (3) @(posedge clk);
    #1 chk({33'h0, irq}, {33'h0, e});
  endtask : see_irq

  // ----------------------------------------------------------------
  // result watcher and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready)
      chk({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    if (sys_fault === 1'b1) faults++;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(eaa_pkg::OFS_CTRL, ok(32'h20));
    rd(eaa_pkg::OFS_HSHK, ok(32'h0));
    rd(eaa_pkg::OFS_ERR, ok(32'h0));
    rd(14'h0014, SLV);
    wr(14'h0014, 32'h0, eaa_pkg::RESP_SLVERR);
    rd(arr(0), SLV);
    for (int b = 0; b < 16; b++) begin
      rnd = lfsr(rnd);
      data[8 * b +: 8] <= rnd;
    end
    wr(eaa_pkg::OFS_HSHK, 32'h1, eaa_pkg::RESP_OKAY);
    rd(eaa_pkg::OFS_HSHK, ok(32'h3));
    // with the hub favoured the command must wait for the ack to drop
    run_cmd(eaa_pkg::EAA_CMD_PROGRAM, 7'h2);
    repeat (20) @(posedge clk);
    #1 chk({33'h0, pc_busy}, 34'h1);
    rd(eaa_pkg::OFS_HSHK, ok(32'h3));
    wr(eaa_pkg::OFS_HSHK, 32'h0, eaa_pkg::RESP_OKAY);
    wait_done();
    wr(eaa_pkg::OFS_HSHK, 32'h1, eaa_pkg::RESP_OKAY);
    for (int b = 0; b < 16; b++) begin
      rd(arr(32 + b), ok({24'h0, data[8 * b +: 8]}));
    end
    wr(arr(33), 32'h0, eaa_pkg::RESP_SLVERR);
    rd(arr(33), ok({24'h0, data[15:8]}));
    wr(eaa_pkg::OFS_IRQ_MSK, 32'h1, eaa_pkg::RESP_OKAY);
    wr(eaa_pkg::OFS_CTRL, 32'h2, eaa_pkg::RESP_OKAY);
    rd(eaa_pkg::OFS_CTRL, ok(32'h22));
    run_cmd(eaa_pkg::EAA_CMD_ERASE_SECTOR, 7'h3);
    while (pc_busy !== 1'b1) @(posedge clk);
    rd(eaa_pkg::OFS_HSHK, ok(32'h1));
    rd(arr(0), SLV);
    rd(eaa_pkg::OFS_ERR, ok(32'h1));
    see_irq(1'b1);
    rd(eaa_pkg::OFS_ERR, ok(32'h0));
    wait_done();
    rd(arr(37), ok(32'hff));
    // done event stays masked until the mask widens
    wr(eaa_pkg::OFS_IRQ_ST, 32'h1, eaa_pkg::RESP_OKAY);
    see_irq(1'b0);
    wr(eaa_pkg::OFS_IRQ_MSK, 32'h3, eaa_pkg::RESP_OKAY);
    see_irq(1'b1);
    wr(eaa_pkg::OFS_IRQ_ST, 32'h2, eaa_pkg::RESP_OKAY);
    see_irq(1'b0);
    run_cmd(eaa_pkg::EAA_CMD_ERASE_ALL, 7'h0);
    wait_done();
    rd(arr(2047), ok(32'hff));
    wr(eaa_pkg::OFS_CTRL, 32'h10, eaa_pkg::RESP_OKAY);
    rd(eaa_pkg::OFS_CTRL, ok(32'h10));
    rd(eaa_pkg::OFS_HSHK, ok(32'h1));
    rd(arr(0), SLV);
    wr(eaa_pkg::OFS_CTRL, 32'h0, eaa_pkg::RESP_OKAY);
    rd(eaa_pkg::OFS_CTRL, ok(32'h20));
    // let the watcher take the last read before the verdict
    @(posedge clk);
    chk(34'(faults), 34'h1);
    tally_and_finish();
  end
endmodule : test_eaa_arbiter
